// [verilog/hpr_cfg.svh]
// Constants shared by both ends of the two-wire pointer-register link.
`ifndef HPR_CFG_SVH
`define HPR_CFG_SVH

`define HPR_DEV_ADDR 7'h06
`define HPR_BYTE_BITS 4'h8
`define HPR_ACK_SLOT 4'h9
`define HPR_CNT_ZERO 4'h0
`define HPR_CNT_STEP 4'h1
`define HPR_PTR_RESET 8'h00
`define HPR_PTR_STEP 8'h01
`define HPR_CLK_NS 5
`define HPR_SCL_PERIOD_NS 2500
`define HPR_QTR_CYC ((`HPR_SCL_PERIOD_NS / 4) / `HPR_CLK_NS)

`endif

// [verilog/hpr_pkg.sv]
// Types shared by both ends of the two-wire pointer-register link.
package hpr_pkg;

    typedef enum logic [2:0] {
        DEV_IDLE,
        DEV_ADDR,
        DEV_PTR,
        DEV_WDATA,
        DEV_RDATA,
        DEV_IGNORE
    } hpr_dev_state_type;

    typedef enum logic [1:0] {
        MST_IDLE,
        MST_START,
        MST_BYTE,
        MST_STOP
    } hpr_mst_state_type;

    typedef enum logic [1:0] {
        OP_START,
        OP_STOP,
        OP_WRITE,
        OP_READ
    } hpr_op_type;

endpackage : hpr_pkg

// [verilog/hpr_link_if.sv]
// Two-wire link between bus master and target, with pull-up resolution of both lines.
`timescale 1ns/1ps
`default_nettype none

interface hpr_link_if;
    logic link_clk;
    logic scl_out;
    logic scl_oe_n;
    logic m_sda_out;
    logic m_sda_oe_n;
    logic d_sda_out;
    logic d_sda_oe_n;
    logic scl;
    logic sda;

    // Both lines are pulled high unless a party enables its low drive.
    assign scl = scl_oe_n ? 1'h1 : scl_out;
    assign sda = (m_sda_oe_n ? 1'h1 : m_sda_out) & (d_sda_oe_n ? 1'h1 : d_sda_out);

    modport mst (
        output scl_out,
        output scl_oe_n,
        output m_sda_out,
        output m_sda_oe_n,
        input scl,
        input sda
    );

    modport dev (
        input link_clk,
        input scl,
        input sda,
        output d_sda_out,
        output d_sda_oe_n
    );

endinterface : hpr_link_if

`default_nettype wire

// [verilog/hpr_dev.sv]
// Two-wire target end: address match, register pointer, auto-incrementing reads and writes.
//
// Summary of operation
// - eight bits MSB first, then acknowledge slot
// - SDA changes only while SCL low
// - SDA falling with SCL high is START
// - SDA rising with SCL high is STOP
// - target never makes START/STOP, drives low only
// - target acknowledges each received byte, ninth cycle
// - master acks read bytes, NACKs last, STOP
// - first byte: address 0000110 plus direction bit
// - matching address acknowledged after direction bit
// - first write byte loads the pointer
// - pointer kept between transfers for reads
// - read data starts right after address acknowledge
// - master ack on read advances pointer by one
// - pointer set then repeated START for reads
// - every register write begins with pointer byte
// - master releases SDA for each write acknowledge slot
// - each accepted write byte advances the pointer
// - master ends write with STOP
// - no idle SCL cycles inside a transfer
// - only the master drives SCL
`timescale 1ns/1ps
`default_nettype none
`include "hpr_cfg.svh"

module hpr_dev (
    hpr_link_if.dev link,
    input wire logic clk,
    input wire logic rst,
    output logic wr_stb,
    output logic rd_stb,
    output logic [7:0] reg_addr,
    output logic [7:0] wr_data,
    input wire logic [7:0] rd_data
);

    ////////////////////////////////////////////////////////////////////////
    // Link domain: pin synchronisers and edge detection.
    logic scl_s1_q, scl_s2_q, scl_p_q, sda_s1_q, sda_s2_q, sda_p_q;
    logic start_det, stop_det, scl_rise, scl_fall;

    always_ff @(posedge link.link_clk or posedge rst) begin
        if (rst) begin
            scl_s1_q <= 1'h1;
            scl_s2_q <= 1'h1;
            scl_p_q <= 1'h1;
            sda_s1_q <= 1'h1;
            sda_s2_q <= 1'h1;
            sda_p_q <= 1'h1;
        end else begin
            scl_s1_q <= link.scl;
            scl_s2_q <= scl_s1_q;
            scl_p_q <= scl_s2_q;
            sda_s1_q <= link.sda;
            sda_s2_q <= sda_s1_q;
            sda_p_q <= sda_s2_q;
        end
    end

    assign start_det = scl_s2_q & scl_p_q & sda_p_q & ~sda_s2_q;
    assign stop_det = scl_s2_q & scl_p_q & ~sda_p_q & sda_s2_q;
    assign scl_rise = scl_s2_q & ~scl_p_q;
    assign scl_fall = ~scl_s2_q & scl_p_q;

    ////////////////////////////////////////////////////////////////////////
    // Link domain: byte engine, pointer and SDA drive.
    hpr_pkg::hpr_dev_state_type state_q;
    logic [3:0] cnt_q;
    logic [7:0] shift_q, ptr_q, tx_q, wr_addr_q, wr_byte_q, rd_addr_q, rd_buf_q;
    logic rw_q, mack_q, drive_q, wr_tgl_q, rd_tgl_q;

    // The target only ever pulls SDA low; the output value is fixed.
    assign link.d_sda_out = 1'h0;
    assign link.d_sda_oe_n = ~drive_q;

    always_ff @(posedge link.link_clk or posedge rst) begin
        if (rst) begin
            state_q <= hpr_pkg::DEV_IDLE;
            cnt_q <= `HPR_CNT_ZERO;
            shift_q <= 8'h00;
            ptr_q <= `HPR_PTR_RESET;
            tx_q <= 8'h00;
            rw_q <= 1'h0;
            mack_q <= 1'h1;
            drive_q <= 1'h0;
            wr_tgl_q <= 1'h0;
            rd_tgl_q <= 1'h0;
            wr_addr_q <= 8'h00;
            wr_byte_q <= 8'h00;
            rd_addr_q <= 8'h00;
        end else if (start_det) begin
            // A repeated START also lands here and discards any partial byte.
            state_q <= hpr_pkg::DEV_ADDR;
            cnt_q <= `HPR_CNT_ZERO;
            drive_q <= 1'h0;
        end else if (stop_det) begin
            state_q <= hpr_pkg::DEV_IDLE;
            cnt_q <= `HPR_CNT_ZERO;
            drive_q <= 1'h0;
        end else if (state_q != hpr_pkg::DEV_IDLE && scl_rise) begin
            if (cnt_q < `HPR_BYTE_BITS) begin
                shift_q <= {shift_q[6:0], sda_s2_q};
                cnt_q <= cnt_q + `HPR_CNT_STEP;
            end else if (cnt_q == `HPR_BYTE_BITS) begin
                mack_q <= sda_s2_q;
                cnt_q <= `HPR_ACK_SLOT;
                // Fetch the next byte as soon as the master acks, half a
                // bit time ahead of the edge where it must be on the line.
                if (state_q == hpr_pkg::DEV_RDATA && !sda_s2_q) begin
                    rd_addr_q <= ptr_q + `HPR_PTR_STEP;
                    rd_tgl_q <= ~rd_tgl_q;
                end
            end
        end else if (state_q != hpr_pkg::DEV_IDLE && scl_fall) begin
            if (cnt_q == `HPR_BYTE_BITS) begin
                case (state_q)
                    hpr_pkg::DEV_ADDR: begin
                        if (shift_q[7:1] == `HPR_DEV_ADDR) begin
                            drive_q <= 1'h1;
                            rw_q <= shift_q[0];
                            if (shift_q[0]) begin
                                rd_addr_q <= ptr_q;
                                rd_tgl_q <= ~rd_tgl_q;
                            end
                        end else begin
                            state_q <= hpr_pkg::DEV_IGNORE;
                        end
                    end
                    hpr_pkg::DEV_PTR: begin
                        ptr_q <= shift_q;
                        drive_q <= 1'h1;
                    end
                    hpr_pkg::DEV_WDATA: begin
                        wr_addr_q <= ptr_q;
                        wr_byte_q <= shift_q;
                        wr_tgl_q <= ~wr_tgl_q;
                        drive_q <= 1'h1;
                    end
                    default: begin
                        drive_q <= 1'h0;
                    end
                endcase
            end else if (cnt_q == `HPR_ACK_SLOT) begin
                cnt_q <= `HPR_CNT_ZERO;
                drive_q <= 1'h0;
                case (state_q)
                    hpr_pkg::DEV_ADDR: begin
                        if (rw_q) begin
                            state_q <= hpr_pkg::DEV_RDATA;
                            tx_q <= rd_buf_q;
                            drive_q <= ~rd_buf_q[7];
                        end else begin
                            state_q <= hpr_pkg::DEV_PTR;
                        end
                    end
                    hpr_pkg::DEV_PTR: begin
                        state_q <= hpr_pkg::DEV_WDATA;
                    end
                    hpr_pkg::DEV_WDATA: begin
                        ptr_q <= ptr_q + `HPR_PTR_STEP;
                    end
                    hpr_pkg::DEV_RDATA: begin
                        if (!mack_q) begin
                            ptr_q <= ptr_q + `HPR_PTR_STEP;
                            tx_q <= rd_buf_q;
                            drive_q <= ~rd_buf_q[7];
                        end else begin
                            // A NACK ends the read; stay off the line until STOP or a repeated START.
                            state_q <= hpr_pkg::DEV_IGNORE;
                        end
                    end
                    default: begin
                        state_q <= state_q;
                    end
                endcase
            end else if (state_q == hpr_pkg::DEV_RDATA && cnt_q != `HPR_CNT_ZERO) begin
                tx_q <= {tx_q[6:0], 1'h0};
                drive_q <= ~tx_q[6];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Crossing: toggles from the link domain, data words held stable.
    logic wr_t1_q, wr_t2_q, wr_t3_q, rd_t1_q, rd_t2_q, rd_t3_q;
    logic rd_pend_q, ack_tgl_q, wr_stb_q, rd_stb_q;
    logic [7:0] rd_hold_q, reg_addr_q, wr_data_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_t1_q <= 1'h0;
            wr_t2_q <= 1'h0;
            wr_t3_q <= 1'h0;
            rd_t1_q <= 1'h0;
            rd_t2_q <= 1'h0;
            rd_t3_q <= 1'h0;
        end else begin
            wr_t1_q <= wr_tgl_q;
            wr_t2_q <= wr_t1_q;
            wr_t3_q <= wr_t2_q;
            rd_t1_q <= rd_tgl_q;
            rd_t2_q <= rd_t1_q;
            rd_t3_q <= rd_t2_q;
        end
    end

    // Address and data are written in the same link cycle as the toggle, which then
    // passes two synchroniser stages, so they are stable when captured here.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_stb_q <= 1'h0;
            rd_stb_q <= 1'h0;
            reg_addr_q <= 8'h00;
            wr_data_q <= 8'h00;
        end else begin
            wr_stb_q <= wr_t2_q ^ wr_t3_q;
            rd_stb_q <= rd_t2_q ^ rd_t3_q;
            if (wr_t2_q ^ wr_t3_q) begin
                reg_addr_q <= wr_addr_q;
                wr_data_q <= wr_byte_q;
            end else if (rd_t2_q ^ rd_t3_q) begin
                reg_addr_q <= rd_addr_q;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_pend_q <= 1'h0;
            rd_hold_q <= 8'h00;
            ack_tgl_q <= 1'h0;
        end else begin
            rd_pend_q <= rd_stb_q;
            if (rd_pend_q) begin
                rd_hold_q <= rd_data;
                ack_tgl_q <= ~ack_tgl_q;
            end
        end
    end

    assign wr_stb = wr_stb_q;
    assign rd_stb = rd_stb_q;
    assign reg_addr = reg_addr_q;
    assign wr_data = wr_data_q;

    ////////////////////////////////////////////////////////////////////////
    // Link domain: read data returning from the register side.
    logic ack_a1_q, ack_a2_q, ack_a3_q;

    always_ff @(posedge link.link_clk or posedge rst) begin
        if (rst) begin
            ack_a1_q <= 1'h0;
            ack_a2_q <= 1'h0;
            ack_a3_q <= 1'h0;
            rd_buf_q <= 8'h00;
        end else begin
            ack_a1_q <= ack_tgl_q;
            ack_a2_q <= ack_a1_q;
            ack_a3_q <= ack_a2_q;
            if (ack_a2_q ^ ack_a3_q) begin
                rd_buf_q <= rd_hold_q;
            end
        end
    end

endmodule : hpr_dev

`default_nettype wire

// [verilog/hpr_mst.sv]
// Two-wire bus master end: byte-level command port, SCL made by a divider.
`timescale 1ns/1ps
`default_nettype none
`include "hpr_cfg.svh"

module hpr_mst (
    hpr_link_if.mst link,
    input wire logic clk,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire hpr_pkg::hpr_op_type cmd_op,
    input wire logic [7:0] cmd_data,
    input wire logic cmd_ack,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic rsp_nack
);

    ////////////////////////////////////////////////////////////////////////
    // SDA synchroniser and quarter-bit timer.

    logic sda_s1_q;
    logic sda_s2_q;
    logic [7:0] qcnt_q;
    logic tick;
    logic accept;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sda_s1_q <= 1'h1;
            sda_s2_q <= 1'h1;
        end else begin
            sda_s1_q <= link.sda;
            sda_s2_q <= sda_s1_q;
        end
    end

    assign tick = (qcnt_q == 8'(`HPR_QTR_CYC - 1));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            qcnt_q <= 8'h00;
        end else if (accept || tick) begin
            qcnt_q <= 8'h00;
        end else begin
            qcnt_q <= qcnt_q + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: START, STOP and nine-bit byte slots.

    hpr_pkg::hpr_mst_state_type state_q;
    logic [1:0] q_q;
    logic [3:0] bit_q;
    logic [7:0] tx_q;
    logic [7:0] rx_q;
    logic rd_q;
    logic ack_q;
    logic nack_q;
    logic scl_low_q;
    logic sda_low_q;
    logic ready_q;
    logic rsp_valid_q;
    logic [7:0] rsp_data_q;
    logic rsp_nack_q;

    assign accept = cmd_valid & ready_q;
    assign link.scl_out = 1'h0;
    assign link.scl_oe_n = ~scl_low_q;
    assign link.m_sda_out = 1'h0;
    assign link.m_sda_oe_n = ~sda_low_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= hpr_pkg::MST_IDLE;
            q_q <= 2'h0;
            bit_q <= `HPR_CNT_ZERO;
            tx_q <= 8'h00;
            rx_q <= 8'h00;
            rd_q <= 1'h0;
            ack_q <= 1'h0;
            nack_q <= 1'h1;
            scl_low_q <= 1'h0;
            sda_low_q <= 1'h0;
            ready_q <= 1'h1;
            rsp_valid_q <= 1'h0;
            rsp_data_q <= 8'h00;
            rsp_nack_q <= 1'h0;
        end else begin
            rsp_valid_q <= 1'h0;
            if (accept) begin
                ready_q <= 1'h0;
                q_q <= 2'h0;
                bit_q <= `HPR_CNT_ZERO;
                scl_low_q <= 1'h1;
                case (cmd_op)
                    hpr_pkg::OP_START: begin
                        state_q <= hpr_pkg::MST_START;
                        sda_low_q <= 1'h0;
                    end
                    hpr_pkg::OP_STOP: begin
                        state_q <= hpr_pkg::MST_STOP;
                        sda_low_q <= 1'h1;
                    end
                    default: begin
                        state_q <= hpr_pkg::MST_BYTE;
                        rd_q <= (cmd_op == hpr_pkg::OP_READ);
                        ack_q <= cmd_ack;
                        tx_q <= cmd_data;
                        // A read releases SDA for all eight data bits.
                        sda_low_q <= (cmd_op == hpr_pkg::OP_WRITE) & ~cmd_data[7];
                    end
                endcase
            end else if (tick && state_q != hpr_pkg::MST_IDLE) begin
                q_q <= q_q + 2'h1;
                case (state_q)
                    hpr_pkg::MST_START: begin
                        case (q_q)
                            2'h0: scl_low_q <= 1'h0;
                            2'h1: sda_low_q <= 1'h1;
                            2'h2: scl_low_q <= 1'h1;
                            default: begin
                                state_q <= hpr_pkg::MST_IDLE;
                                ready_q <= 1'h1;
                            end
                        endcase
                    end
                    hpr_pkg::MST_STOP: begin
                        case (q_q)
                            2'h0: scl_low_q <= 1'h0;
                            2'h1: sda_low_q <= 1'h0;
                            2'h2: sda_low_q <= 1'h0;
                            default: begin
                                state_q <= hpr_pkg::MST_IDLE;
                                ready_q <= 1'h1;
                            end
                        endcase
                    end
                    default: begin
                        case (q_q)
                            2'h0: scl_low_q <= 1'h0;
                            2'h1: begin
                                if (bit_q < `HPR_BYTE_BITS) begin
                                    rx_q <= {rx_q[6:0], sda_s2_q};
                                end else begin
                                    nack_q <= sda_s2_q;
                                end
                            end
                            2'h2: scl_low_q <= 1'h1;
                            default: begin
                                // Apart from the first bit, set at accept, SDA moves only here, a quarter after SCL fell.
                                if (bit_q == `HPR_BYTE_BITS) begin
                                    state_q <= hpr_pkg::MST_IDLE;
                                    ready_q <= 1'h1;
                                    sda_low_q <= 1'h0;
                                    rsp_valid_q <= 1'h1;
                                    rsp_data_q <= rx_q;
                                    rsp_nack_q <= nack_q;
                                end else begin
                                    bit_q <= bit_q + `HPR_CNT_STEP;
                                    tx_q <= {tx_q[6:0], 1'h0};
                                    if (bit_q == `HPR_BYTE_BITS - `HPR_CNT_STEP) begin
                                        sda_low_q <= rd_q & ack_q;
                                    end else begin
                                        sda_low_q <= ~rd_q & ~tx_q[6];
                                    end
                                end
                            end
                        endcase
                    end
                endcase
            end
        end
    end

    assign cmd_ready = ready_q;
    assign rsp_valid = rsp_valid_q;
    assign rsp_data = rsp_data_q;
    assign rsp_nack = rsp_nack_q;

endmodule : hpr_mst

`default_nettype wire

// [tb/hpr_link_monitor.sv]
// Concurrent checks on the two-wire link between the master end and the target end.
`timescale 1ns/1ps
`default_nettype none

module hpr_link_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic link_clk,
    input wire logic scl_out,
    input wire logic scl_oe_n,
    input wire logic m_sda_out,
    input wire logic m_sda_oe_n,
    input wire logic d_sda_out,
    input wire logic d_sda_oe_n,
    input wire logic scl,
    input wire logic sda
);
    localparam int LOW_MIN = 400;
    localparam int LOW_MAX = 3800;
    logic [11:0] low_cnt_q;

    ////////////////////////////////////////////////////////////////
    // One SCL cycle spans about 416 link clocks, so a target low drive is at least one bit
    // long and at most nine (acknowledge followed by a read byte of zeros).
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            low_cnt_q <= 12'h000;
        end else if (d_sda_oe_n) begin
            low_cnt_q <= 12'h000;
        end else if (low_cnt_q != 12'hFFF) begin
            low_cnt_q <= low_cnt_q + 12'h001;
        end
    end

    ////////////////////////////////////////////////////////////////
    AST_DEV_LOW_ONLY: assert property (@(posedge link_clk) disable iff (rst)
        $fell(sda) && scl |-> d_sda_oe_n) else $error("target pulled SDA with SCL high");
    AST_DEV_EDGE_SCL_LOW: assert property (@(posedge link_clk) disable iff (rst)
        ($fell(d_sda_oe_n) || $rose(d_sda_oe_n)) |-> !scl) else $error("target moved SDA, SCL high");
    AST_DEV_LOW_SPAN: assert property (@(posedge link_clk) disable iff (rst)
        $rose(d_sda_oe_n) |-> low_cnt_q >= LOW_MIN && low_cnt_q <= LOW_MAX)
        else $error("target low drive has a wrong length");
    AST_MST_SCL_LOW_ONLY: assert property (@(posedge clk) disable iff (rst)
        $fell(scl) |=> (!scl) [*8]) else $error("SCL low phase too short");
    AST_MST_SDA_LOW_ONLY: assert property (@(posedge clk) disable iff (rst)
        $changed(m_sda_oe_n) && !scl |-> $past(scl, 8) == 1'h0)
        else $error("master moved SDA too soon after SCL fell");
    AST_START_HOLD: assert property (@(posedge clk) disable iff (rst)
        $fell(sda) && scl |=> scl [*8]) else $error("SCL fell right after a start");
    AST_STOP_HOLD: assert property (@(posedge clk) disable iff (rst)
        $rose(sda) && scl |=> sda [*8]) else $error("SDA fell right after a stop");
    AST_SCL_HIGH_MIN: assert property (@(posedge clk) disable iff (rst)
        $rose(scl) |=> scl [*8]) else $error("SCL high phase too short");

endmodule : hpr_link_monitor

`default_nettype wire

// [tb/i2c_pointer_register_slave_bench.sv]
// Bench joining the master end and the target end, with a register file behind the target.
`timescale 1ns/1ps
`default_nettype none
`include "hpr_cfg.svh"

module i2c_pointer_register_slave_bench;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic cmd_valid = 1'h0;
    hpr_pkg::hpr_op_type cmd_op = hpr_pkg::OP_STOP;
    logic [7:0] cmd_data = 8'h00;
    logic cmd_ack = 1'h0;
    logic cmd_ready, rsp_valid, rsp_nack, wr_stb, rd_stb;
    logic [7:0] rsp_data, reg_addr, wr_data, rd_data, ptr, base, d;
    logic [6:0] bad;
    logic [7:0] regs [256];
    logic [7:0] mirror [256];
    logic [15:0] q_rsp [$];
    logic [15:0] q_wr [$];
    logic [15:0] q_rd [$];
    logic [31:0] seed = 32'hA88B72FD;
    int err_total = 0;
    int n_compared = 0;

    hpr_link_if link ();
    hpr_mst hpr_mst_inst (.link(link), .clk(clk), .rst(rst), .cmd_valid(cmd_valid),
        .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_ack(cmd_ack), .cmd_ready(cmd_ready),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack));
    hpr_dev hpr_dev_inst (.link(link), .clk(clk), .rst(rst), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .reg_addr(reg_addr), .wr_data(wr_data), .rd_data(rd_data));
    hpr_link_monitor hpr_link_monitor_inst (.clk(clk), .rst(rst), .link_clk(link.link_clk),
        .scl_out(link.scl_out), .scl_oe_n(link.scl_oe_n), .m_sda_out(link.m_sda_out),
        .m_sda_oe_n(link.m_sda_oe_n), .d_sda_out(link.d_sda_out),
        .d_sda_oe_n(link.d_sda_oe_n), .scl(link.scl), .sda(link.sda));

    always #2.5 clk = ~clk;
    initial begin
        link.link_clk = 1'h0;
        #1.7;
        forever #3 link.link_clk = ~link.link_clk;
    end
    assign rd_data = regs[reg_addr];
    always @(posedge clk) begin
        if (wr_stb === 1'h1) regs[reg_addr] <= wr_data;
    end

    ////////////////////////////////////////////////////////////////
    function automatic logic [7:0] rnd8();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd8

    task automatic tally(input string what, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask : tally

    task automatic cmp_rsp();
        tally("rsp", q_rsp.size() ? q_rsp.pop_front() : 16'hXXXX, {7'h00, rsp_nack, rsp_data});
    endtask : cmp_rsp
    task automatic cmp_wr();
        tally("wr", q_wr.size() ? q_wr.pop_front() : 16'hXXXX, {reg_addr, wr_data});
    endtask : cmp_wr
    task automatic cmp_rd();
        tally("rd_addr", q_rd.size() ? q_rd.pop_front() : 16'hXXXX, {8'h00, reg_addr});
    endtask : cmp_rd

    // Outputs are registered on the rising edge, so the falling edge sees them settled.
    always @(negedge clk) begin
        if (rsp_valid === 1'h1) cmp_rsp();
        if (wr_stb === 1'h1) cmp_wr();
        if (rd_stb === 1'h1) cmp_rd();
    end

    ////////////////////////////////////////////////////////////////
    task automatic wait_ready();
        int n;
        n = 0;
        while (cmd_ready !== 1'h1 && n < 6000) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 6000) err_total++;
    endtask : wait_ready

    task automatic do_cmd(input hpr_pkg::hpr_op_type op, input logic [7:0] dat, input logic ack);
        @(posedge clk);
        #1;
        wait_ready();
        cmd_valid = 1'h1;
        cmd_op = op;
        cmd_data = dat;
        cmd_ack = ack;
        @(posedge clk);
        #1;
        cmd_valid = 1'h0;
    endtask : do_cmd

    task automatic wr_byte(input logic [7:0] dat, input logic nack);
        q_rsp.push_back({7'h00, nack, dat});
        do_cmd(hpr_pkg::OP_WRITE, dat, 1'h0);
    endtask : wr_byte

    // The master answers every byte but the last; each answer moves the pointer on.
    task automatic read_xfer(input int n);
        do_cmd(hpr_pkg::OP_START, rnd8(), 1'h0);
        q_rd.push_back({8'h00, ptr});
        wr_byte({`HPR_DEV_ADDR, 1'h1}, 1'h0);
        for (int i = 1; i <= n; i++) begin
            q_rsp.push_back({7'h00, i == n, mirror[ptr]});
            if (i < n) ptr++;
            if (i < n) q_rd.push_back({8'h00, ptr});
            do_cmd(hpr_pkg::OP_READ, rnd8(), i < n);
        end
        do_cmd(hpr_pkg::OP_STOP, rnd8(), 1'h0);
    endtask : read_xfer

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results

    ////////////////////////////////////////////////////////////////
    initial begin
        for (int i = 0; i < 256; i++) begin
            regs[i] = 8'(i) ^ 8'h5A;
            mirror[i] = 8'(i) ^ 8'h5A;
        end
        repeat (16) @(posedge clk);
        #1;
        rst = 1'h0;
        tally("idle", 16'h0007, {13'h0000, link.scl, link.sda, cmd_ready});
        base = rnd8();
        ptr = base;
        do_cmd(hpr_pkg::OP_START, rnd8(), 1'h0);
        wr_byte({`HPR_DEV_ADDR, 1'h0}, 1'h0);
        wr_byte(base, 1'h0);
        repeat (2) begin
            d = rnd8();
            q_wr.push_back({ptr, d});
            mirror[ptr] = d;
            ptr++;
            wr_byte(d, 1'h0);
        end
        do_cmd(hpr_pkg::OP_STOP, rnd8(), 1'h0);
        read_xfer(2);
        do_cmd(hpr_pkg::OP_START, rnd8(), 1'h0);
        wr_byte({`HPR_DEV_ADDR, 1'h0}, 1'h0);
        ptr = base;
        wr_byte(base, 1'h0);
        read_xfer(2);
        bad = 7'(rnd8());
        if (bad == `HPR_DEV_ADDR) bad = bad ^ 7'h01;
        do_cmd(hpr_pkg::OP_START, rnd8(), 1'h0);
        wr_byte({bad, seed[8]}, 1'h1);
        wr_byte(rnd8(), 1'h1);
        do_cmd(hpr_pkg::OP_STOP, rnd8(), 1'h0);
        read_xfer(1);
        wait_ready();
        tally("pending", 16'h0000, 16'(q_rsp.size() + q_wr.size() + q_rd.size()));
        results();
    end

    // Sixteen bytes at 4500 clocks each plus start and stop phases need about 80000 clocks.
    initial begin
        #490000;
        err_total++;
        results();
    end

endmodule : i2c_pointer_register_slave_bench

`default_nettype wire
